// >>> host_link.sv
// Host model driving the three-wire programming link
`timescale 1ns/100ps

module host_link #(
  parameter int HALF_CYC = 10
) (
  // Clock
  input wire logic clk_i,
  // Observed ready flag
  input wire logic ready_i,
  // Link pins
  output logic serial_clk_o,
  output logic serial_data_o,
  output logic latch_strobe_o
);
  initial begin
    serial_clk_o = 1'h0;
    serial_data_o = 1'h0;
    latch_strobe_o = 1'h0;
  end

  // No programming before the ready flag shows
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (ready_i !== 1'h1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    ok = ready_i;
  endtask

  // Clock idles low; data left inverted since the line has no pull
  task automatic shift_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_i);
      serial_data_o <= w[i];
      repeat (HALF_CYC) @(posedge clk_i);
      serial_clk_o <= 1'h1;
      repeat (HALF_CYC) @(posedge clk_i);
      serial_clk_o <= 1'h0;
    end
    @(posedge clk_i);
    serial_data_o <= ~w[0];
  endtask

  // Strobe raised only after the last bit
  task automatic strobe();
    @(posedge clk_i);
    latch_strobe_o <= 1'h1;
    repeat (HALF_CYC) @(posedge clk_i);
    latch_strobe_o <= 1'h0;
    repeat (HALF_CYC) @(posedge clk_i);
  endtask
endmodule // host_link

// >>> testbench.sv
// Self-checking bench for the transmitter control block
`timescale 1ns/100ps

module testbench;
  localparam int LIMIT = 60000;
  logic clk_i, rst_i, chip_enable_i, ref_in_i, feedback_i, tx_bit_input_i;
  transmitter_serial_control_pkg::wb_req_t wb_req;
  transmitter_serial_control_pkg::pa_setting_t pa_setting;
  logic [31:0] wb_dat;
  logic wb_ack, regulator_en, pfd_ref, vco_en, band_halve, amp_en, obs_pin, obs_oe;
  logic serial_clk, serial_data, latch_strobe, obs_level, ref_prev, pfd_prev, fb_hold;
  int bad_count, compares, cycles, ref_div, ref_rises, pfd_rises;

  // Open-drain pin has a pull-up
  assign obs_level = obs_oe ? obs_pin : 1'h1;

  transmitter_serial_control #(.REG_READY_CYCLES(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .chip_enable_i(chip_enable_i), .serial_clk_i(serial_clk), .serial_data_i(serial_data),
    .latch_strobe_i(latch_strobe), .ref_in_i(ref_in_i), .feedback_i(feedback_i),
    .tx_bit_input_i(tx_bit_input_i), .regulator_enable_o(regulator_en), .pfd_ref_o(pfd_ref),
    .vco_enable_o(vco_en), .band_halve_o(band_halve), .amp_enable_o(amp_en),
    .pa_setting_o(pa_setting), .observation_pin_o(obs_pin), .observation_pin_oe_o(obs_oe)
  );

  host_link u_host (
    .clk_i(clk_i), .ready_i(obs_level), .serial_clk_o(serial_clk),
    .serial_data_o(serial_data), .latch_strobe_o(latch_strobe)
  );

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  // Reference at twelve clocks a period, slow enough for the synchronisers
  always @(posedge clk_i) begin
    ref_div <= (ref_div == 5) ? 0 : ref_div + 1;
    if (ref_div == 5) begin
      ref_in_i <= ~ref_in_i;
    end
    ref_prev <= ref_in_i;
    pfd_prev <= pfd_ref;
    if (ref_in_i && !ref_prev) begin
      ref_rises <= ref_rises + 1;
    end
    if (pfd_ref === 1'h1 && pfd_prev === 1'h0) begin
      pfd_rises <= pfd_rises + 1;
    end
    // Holding feedback low forces a whole-cycle slip
    feedback_i <= fb_hold ? 1'h0 : pfd_ref;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rd);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do @(posedge clk_i); while (wb_ack !== 1'h1);
    rd = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_cycle(1'h0, adr, 32'h0, rd);
    check(rd, exp, "register read");
  endtask

  task automatic ser_write(input logic [23:0] w);
    u_host.shift_word(w);
    u_host.strobe();
    repeat (10) @(posedge clk_i);
  endtask

  task automatic t_defaults();
    logic ok;
    u_host.wait_ready(ok);
    check(32'(ok), 32'h1, "ready flag on pin");
    rd_check(8'h00, 32'(transmitter_serial_control_pkg::REF_RESET));
    rd_check(8'h20, 32'h0);
  endtask

  task automatic t_ref_div();
    int r, d;
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? 1 : ((k == 1) ? 3 : 15);
      ser_write({18'h0, 4'(r), 2'h0});
      rd_check(8'h00, {26'h0, 4'(r), 2'h0});
      while (ref_rises % 60 != 0) @(posedge clk_i);
      d = pfd_rises;
      repeat (720) @(posedge clk_i);
      d = pfd_rises - d;
      check(32'(d >= 60 / r - 1 && d <= 60 / r + 1), 32'h1, "divided rate");
    end
  endtask

  task automatic t_function();
    for (int i = 0; i < 4; i++) begin
      ser_write({12'h0, (i[0] ? 4'h5 : 4'h4), 4'h0, i[1], i[0], 2'h3});
      check(32'(vco_en), 32'(i[0]), "oscillator enable");
      check(32'(amp_en), 32'(i[1]), "amplifier enable");
      check(32'(obs_level), 32'(i[0]), "observed level");
    end
  endtask

  task automatic t_band();
    logic [31:0] rd;
    ser_write(24'h000005);
    check(32'(band_halve), 32'h1, "band halving");
    u_host.shift_word(24'hFFFFFF);
    ser_write(24'h000001);
    check(32'(band_halve), 32'h0, "band after extra bits");
    wb_cycle(1'h1, 8'h04, 32'hFF000005, rd);
    repeat (3) @(posedge clk_i);
    check(32'(band_halve), 32'h1, "band by bus");
    rd_check(8'h04, 32'h00000005);
  endtask

  task automatic t_power();
    logic [6:0] exp;
    for (int s = 0; s < 4; s++) begin
      ser_write({6'h0, 2'(s), 7'h23, 7'h5A, 2'h2});
      for (int t = 0; t < 2; t++) begin
        @(posedge clk_i);
        tx_bit_input_i <= t[0];
        repeat (8) @(posedge clk_i);
        exp = (t == 0 && s == 2) ? 7'h23 : ((t == 0 && s == 3) ? 7'h00 : 7'h5A);
        check(32'(pa_setting), 32'(exp), "power setting");
      end
    end
    check(32'(pa_setting.range), 32'h2, "power range");
  endtask

  task automatic t_lock();
    logic [31:0] rd;
    int lows;
    int lim;
    lim = transmitter_serial_control_pkg::LOCK_ERR_CYC;
    ser_write({12'h0, 4'h1, 4'h0, 2'h3, 2'h3});
    repeat (1200) @(posedge clk_i);
    check(32'(obs_level), 32'h1, "lock on pin");
    wb_cycle(1'h0, transmitter_serial_control_pkg::ADR_STATUS, 32'h0, rd);
    check(32'(rd[transmitter_serial_control_pkg::ST_LOCK_BIT]), 32'h1, "status lock");
    check(32'(rd[15:8] < lim), 32'h1, "lock error");
    @(posedge clk_i);
    fb_hold <= 1'h1;
    repeat (600) @(posedge clk_i);
    check(32'(obs_level), 32'h0, "lock dropped");
    fb_hold <= 1'h0;
    repeat (1300) @(posedge clk_i);
    check(32'(obs_level), 32'h1, "lock regained");
    ser_write({12'h0, 4'h2, 4'h0, 2'h3, 2'h3});
    lows = 0;
    repeat (360) begin
      @(posedge clk_i);
      lows += (obs_level === 1'h0);
    end
    // Narrow lows only: a few cycles in each detector period
    check(32'(lows > 0 && lows < 36), 32'h1, "analog lock pulses");
  endtask

  task automatic t_ce_clear();
    logic ok;
    ser_write(24'h000007);
    @(posedge clk_i);
    chip_enable_i <= 1'h0;
    ser_write(24'h000005);
    check(32'(regulator_en), 32'h0, "regulator off");
    check(32'(vco_en), 32'h0, "oscillator cleared");
    chip_enable_i <= 1'h1;
    u_host.wait_ready(ok);
    check(32'(ok), 32'h1, "ready again");
    rd_check(8'h04, 32'(transmitter_serial_control_pkg::N_RESET));
    rd_check(8'h00, 32'(transmitter_serial_control_pkg::REF_RESET));
    rd_check(8'h0C, 32'(transmitter_serial_control_pkg::FUNC_RESET));
  endtask

  task automatic conclude();
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'h1;
    chip_enable_i = 1'h1;
    ref_in_i = 1'h0;
    feedback_i = 1'h0;
    tx_bit_input_i = 1'h0;
    wb_req = '0;
    {bad_count, compares, cycles, ref_div, ref_rises, pfd_rises} = '0;
    {ref_prev, pfd_prev, fb_hold} = 3'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    t_defaults();
    t_ref_div();
    t_function();
    t_band();
    t_power();
    t_lock();
    t_ce_clear();
    conclude();
  end
endmodule // testbench

// >>> transmitter_serial_control.sv
// Serial-programmed control logic of a UHF transmitter with a Wishbone slave
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/100ps

module transmitter_serial_control #(
  parameter int REG_READY_CYCLES = transmitter_serial_control_pkg::REG_READY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire transmitter_serial_control_pkg::wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins from outside
  input wire logic chip_enable_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic latch_strobe_i,
  input wire logic ref_in_i,
  input wire logic feedback_i,
  input wire logic tx_bit_input_i,
  // Analog and RF controls
  output logic regulator_enable_o,
  output logic pfd_ref_o,
  output logic vco_enable_o,
  output logic band_halve_o,
  output logic amp_enable_o,
  output transmitter_serial_control_pkg::pa_setting_t pa_setting_o,
  // Observation pin, open-drain when analog lock is shown
  output logic observation_pin_o,
  output logic observation_pin_oe_o
);

  localparam int NPIN = 7;
  localparam int P_CE = 0;
  localparam int P_SCK = 1;
  localparam int P_SDA = 2;
  localparam int P_LE = 3;
  localparam int P_REF = 4;
  localparam int P_FB = 5;
  localparam int P_TX = 6;
  localparam int W = transmitter_serial_control_pkg::WORD_W;
  localparam int EW = transmitter_serial_control_pkg::ERR_W;
  localparam logic [EW-1:0] ERR_MAX = 8'hFF;
  localparam logic [EW-1:0] LOCK_LIM = 8'(transmitter_serial_control_pkg::LOCK_ERR_CYC);
  localparam logic [EW-1:0] UNLOCK_LIM = 8'(transmitter_serial_control_pkg::UNLOCK_ERR_CYC);
  localparam logic [2:0] GOOD_RUN = 3'(transmitter_serial_control_pkg::LOCK_GOOD_RUN);
  localparam logic [31:0] READY_LIM = 32'(REG_READY_CYCLES);

  // Lock measurement states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REF_FIRST = 2'b01,
    ST_FB_FIRST = 2'b11
  } meas_state_t;

  function automatic logic [W-1:0] latch_reset(input logic [1:0] idx);
    case (idx)
      transmitter_serial_control_pkg::LATCH_REF: latch_reset = transmitter_serial_control_pkg::REF_RESET;
      transmitter_serial_control_pkg::LATCH_N: latch_reset = transmitter_serial_control_pkg::N_RESET;
      transmitter_serial_control_pkg::LATCH_MOD: latch_reset = transmitter_serial_control_pkg::MOD_RESET;
      default: latch_reset = transmitter_serial_control_pkg::FUNC_RESET;
    endcase
  endfunction

  function automatic logic [1:0] adr_index(input logic [7:0] adr);
    adr_index = adr[3:2];
  endfunction

  // Pin synchronisers; stage one is read only by stage two
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] sync3_q;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {tx_bit_input_i, feedback_i, ref_in_i, latch_strobe_i,
                  serial_data_i, serial_clk_i, chip_enable_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~sync3_q;
  assign fall = ~sync2_q & sync3_q;

  logic ce;
  assign ce = sync2_q[P_CE];

  // Regulator start-up model
  logic [31:0] ready_cnt_q;
  logic ready_q;
  logic reg_en_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ce) begin
      ready_cnt_q <= '0;
      ready_q <= 1'b0;
      reg_en_q <= 1'b0;
    end else begin
      reg_en_q <= 1'b1;
      if (ready_cnt_q >= READY_LIM) begin
        ready_q <= 1'b1;
      end else begin
        ready_cnt_q <= ready_cnt_q + 32'h00000001;
      end
    end
  end

  // Serial link is powered from the regulator
  logic link_live;
  assign link_live = ce && ready_q;

  // Shift register and latches
  logic [W-1:0] shift_q;
  logic [W-1:0] latch_q [4];
  logic wb_wr;
  logic [1:0] wb_idx;

  always_ff @(posedge clk_i) begin
    if (rst_i || !link_live) begin
      shift_q <= '0;
    end else if (rise[P_SCK]) begin
      // Oldest bit falls off the top
      shift_q <= {shift_q[W-2:0], sync2_q[P_SDA]};
    end
  end

  assign wb_idx = adr_index(wb_req_i.adr);
  // Write lands on the edge where the master sees ack
  assign wb_wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_ack_o
                 && (wb_req_i.adr[7:4] == 4'h0) && link_live;

  // Strobe is only sampled on its rise, so a host that keeps it low while
  // shifting gets a whole word
  generate
    for (genvar i = 0; i < 4; i++) begin : g_latch
      always_ff @(posedge clk_i) begin
        if (rst_i || !ce) begin
          latch_q[i] <= latch_reset(2'(i));
        end else if (link_live && rise[P_LE] && shift_q[1:0] == 2'(i)) begin
          latch_q[i] <= shift_q;
        end else if (wb_wr && wb_idx == 2'(i)) begin
          for (int b = 0; b < 3; b++) begin
            if (wb_req_i.sel[b]) begin
              latch_q[i][b*8 +: 8] <= wb_req_i.dat[b*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

  // Field decode
  logic [3:0] ratio;
  logic [3:0] obs_sel;
  logic [1:0] scheme;
  logic [6:0] high_pwr;
  logic [6:0] low_pwr;

  assign ratio = latch_q[transmitter_serial_control_pkg::LATCH_REF]
                 [transmitter_serial_control_pkg::REF_DIV_LSB +: 4];
  assign obs_sel = latch_q[transmitter_serial_control_pkg::LATCH_FUNC]
                   [transmitter_serial_control_pkg::OBSERVE_SELECT_LSB +: 4];
  assign scheme = latch_q[transmitter_serial_control_pkg::LATCH_MOD]
                  [transmitter_serial_control_pkg::SCHEME_LSB +: 2];
  assign high_pwr = latch_q[transmitter_serial_control_pkg::LATCH_MOD]
                    [transmitter_serial_control_pkg::HIGH_POWER_LSB +: 7];
  assign low_pwr = latch_q[transmitter_serial_control_pkg::LATCH_MOD]
                   [transmitter_serial_control_pkg::LOW_POWER_LSB +: 7];

  // Reference divider; a zero ratio would stall the detector, so it acts as one
  logic [3:0] ref_cnt_q;
  logic pfd_ref_q;
  logic [3:0] ratio_eff;

  assign ratio_eff = (ratio == 4'h0) ? 4'h1 : ratio;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ce) begin
      ref_cnt_q <= 4'h1;
      pfd_ref_q <= 1'b0;
    end else begin
      if (rise[P_REF]) begin
        if (ref_cnt_q >= ratio_eff) begin
          ref_cnt_q <= 4'h1;
          pfd_ref_q <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q + 4'h1;
        end
      end else if (fall[P_REF]) begin
        pfd_ref_q <= 1'b0;
      end
    end
  end

  logic pfd_rise;
  logic pfd_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pfd_prev_q <= 1'b0;
    end else begin
      pfd_prev_q <= pfd_ref_q;
    end
  end
  assign pfd_rise = pfd_ref_q && !pfd_prev_q;

  // Phase error measured between divided reference and feedback edges
  meas_state_t meas_q;
  logic [EW-1:0] err_cnt_q;
  logic [EW-1:0] err_last_q;
  logic err_done_q;
  logic fb_rise;
  assign fb_rise = rise[P_FB];

  always_ff @(posedge clk_i) begin
    if (rst_i || !ce) begin
      meas_q <= ST_IDLE;
      err_cnt_q <= '0;
      err_last_q <= '0;
      err_done_q <= 1'b0;
    end else begin
      err_done_q <= 1'b0;
      case (meas_q)
        ST_IDLE: begin
          if (pfd_rise && fb_rise) begin
            err_last_q <= '0;
            err_done_q <= 1'b1;
          end else if (pfd_rise) begin
            meas_q <= ST_REF_FIRST;
            err_cnt_q <= 8'h01;
          end else if (fb_rise) begin
            meas_q <= ST_FB_FIRST;
            err_cnt_q <= 8'h01;
          end
        end
        ST_REF_FIRST, ST_FB_FIRST: begin
          // A repeated edge of the leader means a whole-cycle slip
          if ((meas_q == ST_REF_FIRST && fb_rise) || (meas_q == ST_FB_FIRST && pfd_rise)) begin
            err_last_q <= err_cnt_q;
            err_done_q <= 1'b1;
            meas_q <= ST_IDLE;
          end else if ((meas_q == ST_REF_FIRST && pfd_rise) ||
                       (meas_q == ST_FB_FIRST && fb_rise)) begin
            err_last_q <= ERR_MAX;
            err_done_q <= 1'b1;
            err_cnt_q <= 8'h01;
          end else if (err_cnt_q != ERR_MAX) begin
            err_cnt_q <= err_cnt_q + 8'h01;
          end
        end
        default: meas_q <= ST_IDLE;
      endcase
    end
  end

  // Digital lock with hysteresis
  logic [2:0] good_q;
  logic lock_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !ce) begin
      good_q <= '0;
      lock_q <= 1'b0;
    end else if (err_done_q) begin
      if (err_last_q < LOCK_LIM) begin
        if (good_q != GOOD_RUN) begin
          good_q <= good_q + 3'h1;
        end
        if (good_q == GOOD_RUN - 3'h1) begin
          lock_q <= 1'b1;
        end
      end else begin
        good_q <= '0;
      end
      if (err_last_q >= UNLOCK_LIM) begin
        lock_q <= 1'b0;
      end
    end
  end

  // Observation pin; analog lock pulls low only during the error window
  logic obs_q;
  logic obs_oe_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      obs_q <= 1'b0;
      obs_oe_q <= 1'b1;
    end else begin
      obs_oe_q <= 1'b1;
      case (obs_sel)
        transmitter_serial_control_pkg::OBS_REG_READY: obs_q <= ready_q;
        transmitter_serial_control_pkg::OBS_DIGITAL_LOCK: obs_q <= lock_q;
        transmitter_serial_control_pkg::OBS_ANALOG_LOCK: begin
          obs_q <= 1'b0;
          obs_oe_q <= (meas_q != ST_IDLE);
        end
        transmitter_serial_control_pkg::OBS_PFD_REF: obs_q <= pfd_ref_q;
        transmitter_serial_control_pkg::OBS_HIGH: obs_q <= 1'b1;
        default: obs_q <= 1'b0;
      endcase
    end
  end

  // RF controls
  logic vco_q;
  logic band_q;
  logic amp_q;
  transmitter_serial_control_pkg::pa_setting_t pa_q;
  logic [6:0] pwr_sel;

  always_comb begin
    pwr_sel = high_pwr;
    if (scheme == transmitter_serial_control_pkg::SCHEME_ASK) begin
      pwr_sel = sync2_q[P_TX] ? high_pwr : low_pwr;
    end else if (scheme == transmitter_serial_control_pkg::SCHEME_OOK) begin
      pwr_sel = sync2_q[P_TX] ? high_pwr : 7'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vco_q <= 1'b0;
      band_q <= 1'b0;
      amp_q <= 1'b0;
      pa_q <= '0;
    end else begin
      vco_q <= latch_q[transmitter_serial_control_pkg::LATCH_FUNC]
               [transmitter_serial_control_pkg::VCO_POWER_BIT] && ce;
      band_q <= latch_q[transmitter_serial_control_pkg::LATCH_N]
                [transmitter_serial_control_pkg::BAND_HALVING_BIT];
      amp_q <= latch_q[transmitter_serial_control_pkg::LATCH_FUNC]
               [transmitter_serial_control_pkg::AMP_POWER_BIT] && ce;
      pa_q.range <= pwr_sel[6:5];
      pa_q.level <= pwr_sel[4:0];
    end
  end

  // Wishbone slave: one wait state, ack dropped after one cycle
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic ack_q;

  always_comb begin
    rd_d = 32'h00000000;
    if (wb_req_i.adr[7:4] == 4'h0) begin
      rd_d = {8'h00, latch_q[wb_idx]};
    end else if (wb_req_i.adr == transmitter_serial_control_pkg::ADR_STATUS) begin
      rd_d[transmitter_serial_control_pkg::ST_READY_BIT] = ready_q;
      rd_d[transmitter_serial_control_pkg::ST_LOCK_BIT] = lock_q;
      rd_d[transmitter_serial_control_pkg::ST_CE_BIT] = ce;
      rd_d[transmitter_serial_control_pkg::ST_ERR_LSB +: 8] = err_last_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q <= '0;
    end else begin
      ack_q <= wb_req_i.cyc && wb_req_i.stb && !ack_q;
      rd_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign regulator_enable_o = reg_en_q;
  assign pfd_ref_o = pfd_ref_q;
  assign vco_enable_o = vco_q;
  assign band_halve_o = band_q;
  assign amp_enable_o = amp_q;
  assign pa_setting_o = pa_q;
  assign observation_pin_o = obs_q;
  assign observation_pin_oe_o = obs_oe_q;

endmodule // transmitter_serial_control

// >>> transmitter_serial_control_monitor.sv
// Port-level concurrent checks for the transmitter control block
`timescale 1ns/100ps

module transmitter_serial_control_monitor #(
  parameter int REG_READY_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire transmitter_serial_control_pkg::wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and controls
  input wire logic chip_enable_i,
  input wire logic ref_in_i,
  input wire logic regulator_enable_o,
  input wire logic pfd_ref_o,
  input wire logic vco_enable_o,
  input wire logic amp_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_answer: assert property ($rose(wb_req_i.cyc && wb_req_i.stb) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_read_upper_zero: assert property (wb_ack_o && !wb_req_i.we |-> wb_dat_o[31:24] == 8'h00)
    else $error("read data above 24 bits");
  chk_reg_off: assert property (!chip_enable_i [*6] |-> !regulator_enable_o)
    else $error("regulator on with enable low");
  chk_reg_on: assert property (chip_enable_i [*8] |-> regulator_enable_o)
    else $error("regulator off with enable high");
  chk_vco_cleared: assert property (!chip_enable_i [*6] |-> !vco_enable_o)
    else $error("oscillator on with enable low");
  chk_amp_cleared: assert property (!chip_enable_i [*6] |-> !amp_enable_o)
    else $error("amplifier on with enable low");
  chk_ref_fall: assert property ($fell(ref_in_i) |-> ##[1:6] !pfd_ref_o)
    else $error("divided reference stuck high");
  chk_pfd_needs_ref: assert property ($rose(pfd_ref_o) |-> ref_in_i)
    else $error("divided reference rose without reference");

  cover property ($rose(vco_enable_o));
  cover property (wb_ack_o && wb_req_i.we);
  cover property ($fell(regulator_enable_o));
endmodule // transmitter_serial_control_monitor

bind transmitter_serial_control transmitter_serial_control_monitor #(
  .REG_READY_CYCLES(REG_READY_CYCLES)
) u_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .chip_enable_i(chip_enable_i), .ref_in_i(ref_in_i),
  .regulator_enable_o(regulator_enable_o), .pfd_ref_o(pfd_ref_o),
  .vco_enable_o(vco_enable_o), .amp_enable_o(amp_enable_o)
);

// >>> transmitter_serial_control_pkg.sv
// Constants, field layouts and carrier types for the transmitter control block
package transmitter_serial_control_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_MHZ = 250;
  localparam int REG_READY_US = 50;
  localparam int REG_READY_CYC = REG_READY_US * CLK_MHZ;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 25;
  // Below-limit test: error cycles strictly under the rounded-up figure
  localparam int LOCK_ERR_CYC = (LOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // At-limit test: error cycles at or above the rounded-up figure
  localparam int UNLOCK_ERR_CYC = (UNLOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_GOOD_RUN = 5;

  // Serial word
  localparam int WORD_W = 24;

  // Latch index, carried in the two lowest shifted bits
  localparam logic [1:0] LATCH_REF = 2'h0;
  localparam logic [1:0] LATCH_N = 2'h1;
  localparam logic [1:0] LATCH_MOD = 2'h2;
  localparam logic [1:0] LATCH_FUNC = 2'h3;

  // Reference latch fields
  localparam int REF_DIV_LSB = 2;
  localparam int REF_DIV_W = 4;
  // N latch fields
  localparam int BAND_HALVING_BIT = 2;
  // Modulation latch fields
  localparam int HIGH_POWER_LSB = 2;
  localparam int LOW_POWER_LSB = 9;
  localparam int POWER_W = 7;
  localparam int SCHEME_LSB = 16;
  // Function latch fields
  localparam int VCO_POWER_BIT = 2;
  localparam int AMP_POWER_BIT = 3;
  localparam int OBSERVE_SELECT_LSB = 8;
  localparam int OBSERVE_SELECT_W = 4;

  // Values after reset or chip-enable clear
  localparam logic [WORD_W-1:0] REF_RESET = 24'h000004;
  localparam logic [WORD_W-1:0] N_RESET = 24'h000001;
  localparam logic [WORD_W-1:0] MOD_RESET = 24'h000002;
  localparam logic [WORD_W-1:0] FUNC_RESET = 24'h000003;

  // Keying schemes {S2,S1}
  localparam logic [1:0] SCHEME_FSK = 2'h0;
  localparam logic [1:0] SCHEME_GFSK = 2'h1;
  localparam logic [1:0] SCHEME_ASK = 2'h2;
  localparam logic [1:0] SCHEME_OOK = 2'h3;

  // Observation pin selections
  localparam logic [3:0] OBS_REG_READY = 4'h0;
  localparam logic [3:0] OBS_DIGITAL_LOCK = 4'h1;
  localparam logic [3:0] OBS_ANALOG_LOCK = 4'h2;
  localparam logic [3:0] OBS_PFD_REF = 4'h3;
  localparam logic [3:0] OBS_LOW = 4'h4;
  localparam logic [3:0] OBS_HIGH = 4'h5;

  // Bus map
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_REF = 8'h00;
  localparam logic [7:0] ADR_N = 8'h04;
  localparam logic [7:0] ADR_MOD = 8'h08;
  localparam logic [7:0] ADR_FUNC = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;

  // Status word bits
  localparam int ST_READY_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_CE_BIT = 2;
  localparam int ST_ERR_LSB = 8;

  localparam int ERR_W = 8;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [1:0] range;
    logic [4:0] level;
  } pa_setting_t;

endpackage
